// >>> sct_tx.sv
// Synchronous character transmitter: sync fill, double buffer, serializer
`timescale 1ns/1ps
// Notes on behaviour
// - Buffer-empty high when both buffer entries free
// - Send whole character; data only after strobe
// - No data strobe: send sync character
// - Sync-sent high when sync character loaded
// - Sync-sent low when data character loaded
// - Length, parity, sync characters set independently
// - Transmit clock independent of receiver clock
// - Buffer holds two while another shifts
// - Sync-sent generated internally
// - Bit rates up to 250K baud
// - One bit per transmit clock rising edge
// - Data strobe loads buffer, sync strobe sync
// - Length code LL5 LH6 HL7 HH8
// - Omit parity high; else odd low, even high
module sct_tx
	import sct_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_tx_bit_clock,
	input wire logic [BUS_W-1:0] i_parallel_in_bus,
	input wire logic i_tx_data_load_strobe,
	input wire logic i_tx_sync_load_strobe,
	input wire logic i_word_len_sel_lo,
	input wire logic i_word_len_sel_hi,
	input wire logic i_parity_omit,
	input wire logic i_parity_odd_even_sel,
	output logic o_tx_buffer_empty,
	output logic o_tx_serial_out,
	output logic o_sync_char_sent
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] char_bits(input logic hi, input logic lo, input logic omit);
		logic [3:0] n;
		n = LEN_BASE + {2'b00, hi, lo};
		char_bits = omit ? n : n + 4'h1;
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic [3:0] len, input logic even);
		logic [7:0] m;
		m = 8'hff >> (4'h8 - len);
		par_bit = ^(d & m) ^ ~even;
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [1:0] tck_sync_reg;
	logic [1:0] dstb_sync_reg;
	logic [1:0] sstb_sync_reg;
	logic [3:0] cfg_s1_reg;
	logic [3:0] cfg_reg;
	logic [BUS_W-1:0] bus_s1_reg;
	logic [BUS_W-1:0] bus_reg;
	logic tck_prev_reg;
	logic dstb_prev_reg;
	logic sstb_prev_reg;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tck_sync_reg <= 2'h0;
			dstb_sync_reg <= 2'h0;
			sstb_sync_reg <= 2'h0;
			cfg_s1_reg <= 4'h0;
			cfg_reg <= 4'h0;
			bus_s1_reg <= 8'h00;
			bus_reg <= 8'h00;
			tck_prev_reg <= 1'b0;
			dstb_prev_reg <= 1'b0;
			sstb_prev_reg <= 1'b0;
		end else begin
			tck_sync_reg <= {tck_sync_reg[0], i_tx_bit_clock};
			dstb_sync_reg <= {dstb_sync_reg[0], i_tx_data_load_strobe};
			sstb_sync_reg <= {sstb_sync_reg[0], i_tx_sync_load_strobe};
			cfg_s1_reg <= {i_word_len_sel_hi, i_word_len_sel_lo, i_parity_omit,
				i_parity_odd_even_sel};
			cfg_reg <= cfg_s1_reg;
			bus_s1_reg <= i_parallel_in_bus;
			bus_reg <= bus_s1_reg;
			tck_prev_reg <= tck_sync_reg[1];
			dstb_prev_reg <= dstb_sync_reg[1];
			sstb_prev_reg <= sstb_sync_reg[1];
		end
	end

	logic bit_tick;
	logic data_stb;
	logic sync_stb;
	assign bit_tick = tck_sync_reg[1] & ~tck_prev_reg;
	assign data_stb = dstb_sync_reg[1] & ~dstb_prev_reg;
	assign sync_stb = sstb_sync_reg[1] & ~sstb_prev_reg;

	// ----------------------------------------
	// Sync register and two-entry data buffer
	// ----------------------------------------
	logic [BUS_W-1:0] sync_char_reg;
	logic [BUS_W-1:0] buf_mem [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic buf_in_ready;
	logic buf_out_valid;
	logic take;
	assign buf_in_ready = count_reg != 2'h2;
	assign buf_out_valid = count_reg != 2'h0;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync_char_reg <= SYNC_RESET;
		end else if (sync_stb) begin
			sync_char_reg <= bus_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			buf_mem[0] <= DATA_RESET;
			buf_mem[1] <= DATA_RESET;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (data_stb && buf_in_ready) begin
				buf_mem[wr_ptr_reg] <= bus_reg;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (take) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + {1'b0, data_stb && buf_in_ready} - {1'b0, take};
		end
	end

	assign o_tx_buffer_empty = count_reg == 2'h0;

	// ----------------------------------------
	// Serializer
	// ----------------------------------------
	sct_state_t state_reg;
	logic [8:0] shift_reg;
	logic [3:0] bits_left_reg;
	logic char_end;
	logic [3:0] nbits;
	logic [3:0] dlen;
	assign dlen = LEN_BASE + {2'b00, cfg_reg[3], cfg_reg[2]};
	assign nbits = char_bits(cfg_reg[3], cfg_reg[2], cfg_reg[1]);
	assign char_end = bit_tick && (state_reg == SCT_IDLE || bits_left_reg == 4'h1);
	assign take = char_end && buf_out_valid;

	// Next character and its parity slot
	logic [7:0] next_char;
	logic [8:0] load_word;
	assign next_char = take ? buf_mem[rd_ptr_reg] : sync_char_reg;
	always_comb begin
		load_word = {1'b0, next_char};
		load_word[dlen] = par_bit(next_char, dlen, cfg_reg[0]);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= SCT_IDLE;
			shift_reg <= 9'h1ff;
			bits_left_reg <= 4'h0;
			o_sync_char_sent <= 1'b0;
		end else if (char_end) begin
			state_reg <= SCT_SEND;
			bits_left_reg <= nbits;
			shift_reg <= load_word;
			o_sync_char_sent <= ~take;
		end else if (bit_tick) begin
			shift_reg <= {1'b1, shift_reg[8:1]};
			bits_left_reg <= bits_left_reg - 4'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tx_serial_out <= 1'b1;
		end else if (char_end) begin
			o_tx_serial_out <= next_char[0];
		end else if (bit_tick) begin
			o_tx_serial_out <= shift_reg[1];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_SYNC_WHEN_NO_DATA: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(char_end && !buf_out_valid) |=> o_sync_char_sent)
		else $error("sync fill not flagged");
	AST_DATA_CLEARS_SYNC: assert property (@(posedge i_clk) disable iff (!i_rstn)
		take |=> !o_sync_char_sent)
		else $error("data char left sync flag set");
	AST_EMPTY_FALLS: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(data_stb && o_tx_buffer_empty && !take) |=> !o_tx_buffer_empty)
		else $error("empty flag did not fall on strobe");
	AST_NO_TAKE_MIDCHAR: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(bit_tick && state_reg == SCT_SEND && bits_left_reg > 4'h1) |-> !take)
		else $error("buffer taken mid character");
	AST_BIT_COUNT: assert property (@(posedge i_clk) disable iff (!i_rstn)
		char_end |=> bits_left_reg == $past(nbits))
		else $error("character length wrong");
	AST_OUT_ON_TICK: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!bit_tick |=> $stable(o_tx_serial_out))
		else $error("serial out moved without clock edge");
	AST_EMPTY_RISES: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(take && count_reg == 2'h1 && !data_stb) |=> o_tx_buffer_empty)
		else $error("empty flag did not rise on last transfer");
	AST_SHIFT_LSB: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(bit_tick && !char_end) |=> o_tx_serial_out == $past(shift_reg[1]))
		else $error("bit order wrong");
	AST_SYNC_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
		sync_stb |=> sync_char_reg == $past(bus_reg))
		else $error("sync character not loaded");
	AST_FULL_DROPS: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(data_stb && !buf_in_ready && !take) |=> count_reg == 2'h2)
		else $error("strobe into full buffer changed fill");
endmodule // sct_tx

// >>> sct_pkg.sv
// Package of constants for the synchronous character transmitter
package sct_pkg;
	// ----------------------------------------
	// Character format
	// ----------------------------------------
	localparam int unsigned BUS_W = 8;
	localparam logic [3:0] LEN_BASE = 4'h5;
	localparam logic [7:0] SYNC_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned MAX_BAUD_K = 250;
	localparam int unsigned MIN_BIT_CYC = (CLK_MHZ * 1000) / MAX_BAUD_K;
	// ----------------------------------------
	// Serializer states
	// ----------------------------------------
	typedef enum logic [0:0] {
		SCT_IDLE = 1'b0,
		SCT_SEND = 1'b1
	} sct_state_t;
endpackage

// >>> sct_line.sv
// Line-side bit clock source for the transmitter
`timescale 1ns/1ps
module sct_line (
	input wire logic i_clk,
	output logic o_tx_bit_clock
);
	initial o_tx_bit_clock = 1'b0;
	// Clock stands low between frames; one rising edge per bit
	task automatic run(input int nbits);
		for (int i = 0; i < nbits; i++) begin
			repeat (8) @(negedge i_clk);
			o_tx_bit_clock = 1'b1;
			repeat (8) @(negedge i_clk);
			o_tx_bit_clock = 1'b0;
		end
	endtask
endmodule // sct_line

// >>> tb_sct_tx.sv
// Self-checking testbench for the synchronous character transmitter
`timescale 1ns/1ps
module tb_sct_tx;
	import sct_pkg::*;
	logic i_clk = 1'b0, i_rstn = 1'b0, i_tx_bit_clock;
	logic [BUS_W-1:0] bus = 8'h00;
	logic dstb = 1'b0, sstb = 1'b0, wlo = 1'b0, whi = 1'b0, pomit = 1'b0, psel = 1'b0;
	logic empty, sout, ssent;
	logic [1:0] expq[$];
	int num_errors = 0, n_compared = 0, seed = 19;
	always #2.5 i_clk = ~i_clk;
	sct_line line (.i_clk(i_clk), .o_tx_bit_clock(i_tx_bit_clock));
	sct_tx dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_tx_bit_clock(i_tx_bit_clock),
		.i_parallel_in_bus(bus), .i_tx_data_load_strobe(dstb), .i_tx_sync_load_strobe(sstb),
		.i_word_len_sel_lo(wlo), .i_word_len_sel_hi(whi), .i_parity_omit(pomit),
		.i_parity_odd_even_sel(psel), .o_tx_buffer_empty(empty), .o_tx_serial_out(sout),
		.o_sync_char_sent(ssent));
	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Host side: strobed loads, expected bits
	// ----------------------------------------
	task automatic load(input logic sync, input logic [7:0] val);
		@(negedge i_clk) bus = val;
		repeat (4) @(negedge i_clk);
		{sstb, dstb} = {sync, ~sync};
		repeat (4) @(negedge i_clk);
		{sstb, dstb} = 2'b00;
		repeat (4) @(negedge i_clk);
	endtask
	task automatic push(input logic [7:0] c, input logic s, input int len);
		logic [7:0] m;
		m = 8'hff >> (8 - len);
		for (int i = 0; i < len; i++) expq.push_back({s, c[i]});
		if (!pomit) expq.push_back({s, psel ? ^(c & m) : ~^(c & m)});
	endtask
	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	initial begin
		logic [1:0] e;
		forever begin
			@(posedge i_tx_bit_clock);
			repeat (6) @(posedge i_clk);
			@(negedge i_clk);
			if (expq.size() == 0) begin
				check("bit_queue", 8'h01, 8'h00);
			end else begin
				e = expq.pop_front();
				check("serial", e[0], sout);
				check("sync_sent", e[1], ssent);
			end
		end
	end
	initial begin
		#400000;
		num_errors++;
		end_of_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int len;
		logic [7:0] sc, d0, d1, d2;
		repeat (16) @(posedge i_clk);
		@(negedge i_clk) i_rstn = 1'b1;
		check("empty", 8'h01, empty);
		check("serial", 8'h01, sout);
		check("sync_sent", 8'h00, ssent);
		for (int r = 0; r < 16; r++) begin
			{pomit, psel, whi, wlo} = r[3:0];
			len = int'(LEN_BASE) + (r % 4);
			sc = 8'($random(seed));
			d0 = 8'($random(seed));
			d1 = 8'($random(seed));
			d2 = 8'($random(seed));
			load(1'b1, sc);
			load(1'b0, d0);
			check("empty", 8'h00, empty);
			load(1'b0, d1);
			load(1'b0, d2);
			push(d0, 1'b0, len);
			push(d1, 1'b0, len);
			push(sc, 1'b1, len);
			line.run(3 * (len + (pomit ? 0 : 1)));
			repeat (8) @(negedge i_clk);
			check("empty", 8'h01, empty);
		end
		check("left_over", 8'h00, 8'(expq.size()));
		end_of_test();
	end
endmodule // tb_sct_tx
